// ---- include/fsp_pkg.sv ----
// Constants for the flash self-programming controller.
// Assumes one 200 MHz clock and a CPU core that strobes store and load operations.
package fsp_pkg;
    // Control register offset on the register port.
    localparam logic [1:0] CTRL_ADDR = 2'h0;
    // Control register bit positions.
    localparam int SPE_BIT = 0;
    localparam int ERS_BIT = 1;
    localparam int WRT_BIT = 2;
    localparam int LBS_BIT = 3;
    localparam int RRE_BIT = 4;
    localparam int BSY_BIT = 6;
    localparam int IE_BIT = 7;
    // Command patterns compared on bits 5..0 (CMD_MASK); bit 6 is masked off and bit 7 is the interrupt enable and is ignored.
    localparam logic [6:0] CMD_MASK = 7'h3f;
    localparam logic [6:0] CMD_LOAD = 7'h01;
    localparam logic [6:0] CMD_ERASE = 7'h03;
    localparam logic [6:0] CMD_WRITE = 7'h05;
    localparam logic [6:0] CMD_LOCK = 7'h09;
    localparam logic [6:0] CMD_RWWEN = 7'h11;
    // Timed windows in CPU cycles.
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    localparam logic [2:0] LOAD_WINDOW = 3'h3;
    // Address pointer values selecting fuse and lock bytes.
    localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
    localparam logic [15:0] Z_LOCK = 16'h0001;
    localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
    // Boot lock bits sit in data_low_reg bits 5..2.
    localparam int LOCK_LSB = 2;
    localparam int LOCK_MSB = 5;
    localparam logic [7:0] LOCK_KEEP_MASK = 8'hc3;
    // Page field of the pointer: bits 12..6; word field: bits 5..1.
    localparam int PAGE_LSB = 6;
    localparam int PAGE_MSB = 12;
    localparam int WORD_LSB = 1;
    localparam int WORD_MSB = 5;
    // Programming time and clock period.
    localparam longint PROG_MIN_NS = 3700000;
    localparam longint PROG_MAX_NS = 4500000;
    localparam longint CLK_PERIOD_NS = 5;
    localparam longint PROG_CYCLES = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        FSP_IDLE = 2'b00,
        FSP_ARMED = 2'b01
    } fsp_arm_t;
    typedef enum logic [1:0] {
        FSP_ENG_IDLE = 2'b00,
        FSP_ENG_RUN = 2'b01,
        FSP_ENG_DONE = 2'b11
    } fsp_eng_t;
    typedef enum logic [1:0] {
        FSP_OP_ERASE = 2'h0,
        FSP_OP_WRITE = 2'h1,
        FSP_OP_LOCK = 2'h2
    } fsp_op_t;
endpackage : fsp_pkg

// ---- hdl/fsp_ctrl.sv ----
// Flash self-programming controller: control register, timed command windows,
// fuse and lock readback, erase, write and lock-bit timing.
// Assumes the CPU core strobes store_op_i and load_op_i for one cycle each, and that
// por_resetn_i drops only when the supply is too low to finish a flash operation.
// Notes on behaviour
// [RULE_01] Erase or write blocks read-while-write section reads.
// [RULE_02] Busy flag stays set while section blocked.
// [RULE_03] Read-enable command clears busy, unblocks section.
// [RULE_04] Software moves vectors or disables interrupts.
// [RULE_05] Lock pattern plus store within four cycles.
// [RULE_06] Lock data from data_low bits 5..2.
// [RULE_07] Pointer ignored for lock programming; recommended 0x0001.
// [RULE_08] Lock programming leaves whole flash readable.
// [RULE_09] EEPROM write refuses programming and fuse reads.
// [RULE_10] Software checks EEPROM busy before writing.
// [RULE_11] Lock read: pointer 0x0001, load within three.
// [RULE_12] Auto-clear on read, load or store timeout.
// [RULE_13] Unarmed load reads program flash normally.
// [RULE_14] Pointer 0x0000 load returns fuse low byte.
// [RULE_15] Pointer 0x0003 load returns fuse high byte.
// [RULE_16] Programmed bits read zero, unprogrammed read one.
// [RULE_17] Reset during write lets write complete.
// [RULE_18] Each flash operation lasts 3.7 to 4.5 ms.
// [RULE_19] Only boot lock bits writable by self-programming.
// [RULE_20] Erase pattern plus store; page from pointer.
// [RULE_21] Write pattern plus store; other bits zero.
// [RULE_22] Buffer load pattern plus store; data registers.
// [RULE_23] Interrupt requested while enable bit is clear.
// [RULE_24] Window counted from control write; expiry discards.
// [RULE_25] Enable set on command, cleared at finish.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module fsp_ctrl #(
    parameter int PROG_CYCLES = int'(fsp_pkg::PROG_CYCLES)
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic por_resetn_i,
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic store_op_i,
    input wire logic load_op_i,
    input wire logic [15:0] addr_ptr_i,
    input wire logic [7:0] data_low_i,
    input wire logic [7:0] data_high_i,
    input wire logic eeprom_write_busy_i,
    input wire logic [7:0] fuse_low_byte_i,
    input wire logic [7:0] fuse_high_byte_i,
    input wire logic [7:0] lock_byte_i,
    output logic [7:0] load_data_o,
    output logic load_special_o,
    output logic rww_read_block_o,
    output logic buf_load_o,
    output logic [4:0] buf_word_o,
    output logic [15:0] buf_data_o,
    output logic buf_clear_o,
    output logic page_erase_o,
    output logic page_write_o,
    output logic [6:0] page_addr_o,
    output logic lock_write_o,
    output logic [7:0] lock_wdata_o,
    output logic spm_irq_o
);
    localparam int CW = $clog2(PROG_CYCLES + 1);

    fsp_pkg::fsp_arm_t arm_r, arm_nxt;
    fsp_pkg::fsp_eng_t eng_r, eng_nxt;
    fsp_pkg::fsp_op_t op_r;
    logic [6:0] cmd_r;
    logic ie_r;
    logic [2:0] win_r;
    logic [CW-1:0] cnt_r;
    logic rww_busy_r;
    logic [7:0] lock_data_r;
    logic [7:0] rdata_nxt;

    // Decode of the armed command and the events of the timed window.
    wire ctrl_sel = (reg_addr_i == fsp_pkg::CTRL_ADDR);
    wire eng_busy = (eng_r != fsp_pkg::FSP_ENG_IDLE);
    wire ctrl_wr = reg_wr_i && ctrl_sel && !eng_busy;
    wire armed = (arm_r == fsp_pkg::FSP_ARMED);
    wire [6:0] cmd_bits = cmd_r & fsp_pkg::CMD_MASK;
    // [RULE_09] EEPROM write blocks
    wire store_ok = armed && (win_r < fsp_pkg::STORE_WINDOW) && store_op_i && !eeprom_write_busy_i;
    // [RULE_11] lock read window
    wire load_ok = armed && (win_r < fsp_pkg::LOAD_WINDOW) && load_op_i && !eeprom_write_busy_i
                   && (cmd_bits == fsp_pkg::CMD_LOCK);
    wire do_load = store_ok && (cmd_bits == fsp_pkg::CMD_LOAD);
    wire do_erase = store_ok && (cmd_bits == fsp_pkg::CMD_ERASE);
    wire do_write = store_ok && (cmd_bits == fsp_pkg::CMD_WRITE);
    wire do_lock = store_ok && (cmd_bits == fsp_pkg::CMD_LOCK);
    wire do_rwwen = store_ok && (cmd_bits == fsp_pkg::CMD_RWWEN);
    wire do_timed = do_erase || do_write || do_lock;
    // [RULE_24] window expiry
    wire expire = armed && (win_r == fsp_pkg::STORE_WINDOW - 3'h1) && !store_ok;
    wire eng_done = (eng_r == fsp_pkg::FSP_ENG_DONE);

    // Value returned for a special load; fuse and lock inputs already read zero when programmed.
    // [RULE_16] programmed reads zero
    wire [7:0] special_val = (addr_ptr_i == fsp_pkg::Z_FUSE_LOW) ? fuse_low_byte_i :
                             (addr_ptr_i == fsp_pkg::Z_FUSE_HIGH) ? fuse_high_byte_i :
                             (addr_ptr_i == fsp_pkg::Z_LOCK) ? lock_byte_i : 8'hff;

    // [RULE_06] boot lock field
    // [RULE_19] keep other lock bits
    wire [7:0] lock_new = lock_byte_i & (data_low_i | fsp_pkg::LOCK_KEEP_MASK);

    // [RULE_12] auto-clear cases
    always_comb begin
        arm_nxt = arm_r;
        if (ctrl_wr && reg_wdata_i[fsp_pkg::SPE_BIT]) begin
            arm_nxt = fsp_pkg::FSP_ARMED;
        end else if (store_ok || load_ok || expire) begin
            arm_nxt = fsp_pkg::FSP_IDLE;
        end
    end

    always_comb begin
        eng_nxt = eng_r;
        case (eng_r)
            fsp_pkg::FSP_ENG_IDLE: begin
                if (do_timed) begin
                    eng_nxt = fsp_pkg::FSP_ENG_RUN;
                end
            end
            fsp_pkg::FSP_ENG_RUN: begin
                if (cnt_r == CW'(PROG_CYCLES - 1)) begin
                    eng_nxt = fsp_pkg::FSP_ENG_DONE;
                end
            end
            default: begin
                eng_nxt = fsp_pkg::FSP_ENG_IDLE;
            end
        endcase
    end

    // Control state on the system reset: an armed command is dropped, while a running operation carries on in the engine.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            arm_r <= fsp_pkg::FSP_IDLE;
            cmd_r <= 7'h00;
            ie_r <= 1'b0;
            win_r <= 3'h0;
        end else begin
            arm_r <= arm_nxt;
            // [RULE_24] count from write
            win_r <= ctrl_wr ? 3'h0 : (armed ? win_r + 3'h1 : 3'h0);
            if (ctrl_wr) begin
                cmd_r <= reg_wdata_i[6:0];
                ie_r <= reg_wdata_i[fsp_pkg::IE_BIT];
            end else if (arm_nxt == fsp_pkg::FSP_IDLE && !(do_timed || eng_busy)) begin
                cmd_r <= 7'h00;
            end else if (eng_done) begin
                cmd_r <= 7'h00;
            end
        end
    end

    // The engine runs on the power-on reset only, so a system reset never cuts an operation short.
    // [RULE_17] survive system reset
    always_ff @(posedge clk_i or negedge por_resetn_i) begin
        if (!por_resetn_i) begin
            eng_r <= fsp_pkg::FSP_ENG_IDLE;
            op_r <= fsp_pkg::FSP_OP_ERASE;
            cnt_r <= '0;
            rww_busy_r <= 1'b0;
            lock_data_r <= 8'hff;
        end else begin
            eng_r <= eng_nxt;
            // [RULE_18] timed programming
            cnt_r <= (eng_r == fsp_pkg::FSP_ENG_RUN) ? cnt_r + CW'(1) : '0;
            if (do_timed) begin
                op_r <= do_erase ? fsp_pkg::FSP_OP_ERASE : (do_write ? fsp_pkg::FSP_OP_WRITE : fsp_pkg::FSP_OP_LOCK);
                lock_data_r <= lock_new;
            end
            // [RULE_02] busy flag held
            // [RULE_08] lock keeps flash readable
            if (do_erase || do_write) begin
                rww_busy_r <= 1'b1;
            // [RULE_03] re-enable clears busy
            end else if (do_rwwen) begin
                rww_busy_r <= 1'b0;
            end
        end
    end

    // [RULE_25] enable bit reflects activity
    wire spe_now = armed || eng_busy;
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd_i && ctrl_sel) begin
            rdata_nxt = {ie_r, rww_busy_r, 1'b0, cmd_r[fsp_pkg::RRE_BIT:fsp_pkg::ERS_BIT], spe_now};
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
            load_data_o <= 8'h00;
            load_special_o <= 1'b0;
            buf_load_o <= 1'b0;
            buf_word_o <= 5'h00;
            buf_data_o <= 16'h0000;
            buf_clear_o <= 1'b0;
            page_erase_o <= 1'b0;
            page_write_o <= 1'b0;
            page_addr_o <= 7'h00;
            spm_irq_o <= 1'b0;
        end else begin
            reg_rdata_o <= rdata_nxt;
            // [RULE_13] normal load otherwise
            // [RULE_14] fuse low readback
            // [RULE_15] fuse high readback
            load_special_o <= load_ok;
            load_data_o <= load_ok ? special_val : 8'h00;
            // [RULE_22] buffer word load
            buf_load_o <= do_load;
            if (do_load) begin
                buf_word_o <= addr_ptr_i[fsp_pkg::WORD_MSB:fsp_pkg::WORD_LSB];
                buf_data_o <= {data_high_i, data_low_i};
            end
            buf_clear_o <= do_rwwen;
            // [RULE_20] page erase start
            // [RULE_21] page write start
            page_erase_o <= do_erase;
            page_write_o <= do_write;
            if (do_erase || do_write) begin
                page_addr_o <= addr_ptr_i[fsp_pkg::PAGE_MSB:fsp_pkg::PAGE_LSB];
            end
            // [RULE_23] interrupt while idle
            spm_irq_o <= ie_r && !spe_now;
        end
    end

    // Lock write and the section block live with the engine so they outlast a system reset.
    always_ff @(posedge clk_i or negedge por_resetn_i) begin
        if (!por_resetn_i) begin
            lock_write_o <= 1'b0;
            lock_wdata_o <= 8'hff;
            rww_read_block_o <= 1'b0;
        end else begin
            // [RULE_05] lock programming commit
            lock_write_o <= (eng_nxt == fsp_pkg::FSP_ENG_DONE) && (eng_r == fsp_pkg::FSP_ENG_RUN)
                            && (op_r == fsp_pkg::FSP_OP_LOCK);
            lock_wdata_o <= lock_data_r;
            // [RULE_01] block section reads
            rww_read_block_o <= rww_busy_r || do_erase || do_write;
        end
    end

    // [RULE_01] block follows busy
    AST_BLOCK_WHILE_BUSY: assert property (@(posedge clk_i) disable iff (!por_resetn_i) // [RULE_01]
        rww_busy_r |=> rww_read_block_o) else $error("section not blocked while busy");
    // [RULE_02] busy flag held
    AST_BUSY_SET: assert property (@(posedge clk_i) disable iff (!por_resetn_i) // [RULE_02]
        (do_erase || do_write) |=> rww_busy_r [*2]) else $error("busy flag not held");
    // [RULE_03] re-enable unblocks section
    AST_RWWEN_CLEAR: assert property (@(posedge clk_i) disable iff (!por_resetn_i) // [RULE_03]
        do_rwwen |=> !rww_busy_r ##1 !rww_read_block_o) else $error("re-enable did not unblock");
    // [RULE_05] four-cycle store window
    AST_STORE_WINDOW: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_05]
        ctrl_wr && reg_wdata_i[fsp_pkg::SPE_BIT] ##1 (!store_op_i && !load_op_i && !ctrl_wr) [*4]
        |-> armed ##1 !armed) else $error("store window length wrong");
    // [RULE_19] other lock bits kept
    AST_LOCK_MASK: assert property (@(posedge clk_i) disable iff (!por_resetn_i) // [RULE_19]
        lock_write_o |-> ((lock_wdata_o & fsp_pkg::LOCK_KEEP_MASK) == (lock_byte_i & fsp_pkg::LOCK_KEEP_MASK)))
        else $error("non-boot lock bits changed");
    // [RULE_08] lock keeps flash readable
    AST_LOCK_NO_BLOCK: assert property (@(posedge clk_i) disable iff (!por_resetn_i) // [RULE_08]
        do_lock && !rww_busy_r |=> !rww_busy_r ##1 !rww_read_block_o) else $error("lock write blocked");
    // [RULE_09] EEPROM write refuses
    AST_EEPROM_REFUSE: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_09]
        eeprom_write_busy_i |-> !store_ok && !load_ok) else $error("operation during EEPROM write");
    // [RULE_15] fuse high readback
    AST_LOAD_RETURN: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_15]
        load_ok && addr_ptr_i == fsp_pkg::Z_FUSE_HIGH |=> load_special_o && load_data_o == $past(fuse_high_byte_i))
        else $error("fuse high not returned");
    // [RULE_14] fuse low readback
    AST_LOAD_FUSE_LOW: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_14]
        load_ok && addr_ptr_i == fsp_pkg::Z_FUSE_LOW |=> load_special_o && load_data_o == $past(fuse_low_byte_i))
        else $error("fuse low not returned");
    // [RULE_11] lock byte readback
    AST_LOAD_LOCK: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_11]
        load_ok && addr_ptr_i == fsp_pkg::Z_LOCK |=> load_special_o && load_data_o == $past(lock_byte_i))
        else $error("lock byte not returned");
    // [RULE_13] unarmed load normal
    AST_LOAD_NORMAL: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_13]
        load_op_i && !armed |=> !load_special_o) else $error("unarmed load was special");
    // [RULE_12] read clears command
    AST_AUTO_CLEAR: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_12]
        load_ok |=> !armed) else $error("lock read did not clear");
    // [RULE_12] expiry clears command
    AST_EXPIRE_CLEAR: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_12]
        expire && !ctrl_wr |=> !armed && cmd_r == '0) else $error("expired command kept");
    // [RULE_24] window starts at write
    AST_WINDOW_START: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_24]
        ctrl_wr && reg_wdata_i[fsp_pkg::SPE_BIT] |=> armed && win_r == '0) else $error("window did not start");
    // [RULE_25] enable clears at finish
    AST_ENABLE_DONE: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_25]
        eng_done |=> !spe_now) else $error("enable still set after finish");
    // [RULE_18] programming time counted
    AST_PROG_TIME: assert property (@(posedge clk_i) disable iff (!por_resetn_i) // [RULE_18]
        eng_done |-> $past(cnt_r) == CW'(PROG_CYCLES - 1)) else $error("programming time wrong");
    // [RULE_23] interrupt while idle
    AST_IRQ: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_23]
        ie_r && !spe_now |=> spm_irq_o) else $error("interrupt not requested");
endmodule : fsp_ctrl

// ---- verification/fsp_cpu_model.sv ----
// CPU core stand-in: writes the control register and issues timed store and load operations.
// Assumes one caller at a time; every signal changes just after a rising edge.
`timescale 1ns/1ps
module fsp_cpu_model (
    input wire logic clk_i,
    input wire logic eeprom_write_busy_i,
    input wire logic [7:0] reg_rdata_i,
    output logic [1:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic store_op_o,
    output logic load_op_o
);
    initial begin
        reg_addr_o = 2'h0;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        store_op_o = 1'b0;
        load_op_o = 1'b0;
    end
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d, input bit ee_wait);
        int n;
        n = 0;
        // wait EEPROM idle.
        // A caller may skip the wait on purpose to see the refusal.
        while (ee_wait && eeprom_write_busy_i && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge clk_i);
        reg_rd_o <= 1'b0;
        #1;
        d = reg_rdata_i;
    endtask : rd_reg
    // atomic timed sequence.
    // Interrupts stay off here, so the gap after the write is exactly the one asked for.
    task automatic op(input int gap, input bit is_load);
        repeat (gap - 1) @(posedge clk_i);
        if (is_load) begin
            load_op_o <= 1'b1;
        end else begin
            store_op_o <= 1'b1;
        end
        @(posedge clk_i);
        load_op_o <= 1'b0;
        store_op_o <= 1'b0;
    endtask : op
endmodule : fsp_cpu_model

// ---- verification/fsp_ctrl_bench.sv ----
// Self-checking bench for the flash self-programming controller.
// Assumes a short programming count so that every timed operation stays brief.
`timescale 1ns/1ps
module fsp_ctrl_bench;
    localparam int PROG = 20;
    logic clk_i, resetn_i, por_resetn_i, eeprom_busy, reg_wr, reg_rd, store_op, load_op;
    logic load_special, rww_block, buf_load, buf_clear, page_erase, page_write, lock_write, spm_irq;
    logic [1:0] reg_addr;
    logic [4:0] buf_word;
    logic [6:0] page_addr;
    logic [7:0] reg_wdata, reg_rdata, data_low, data_high, load_data, lock_wdata;
    logic [7:0] fuse_lo = 8'ha5, fuse_hi = 8'h3c, lock_byte = 8'hec;
    logic [15:0] addr_ptr, buf_data;
    int errors = 0, num_checks = 0, cyc = 0;
    wire [6:0] pulses = {~rww_block, lock_write, page_write, page_erase, buf_clear, buf_load, load_special};
    fsp_ctrl #(.PROG_CYCLES(PROG)) i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .por_resetn_i(por_resetn_i),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .store_op_i(store_op), .load_op_i(load_op), .addr_ptr_i(addr_ptr),
        .data_low_i(data_low), .data_high_i(data_high), .eeprom_write_busy_i(eeprom_busy),
        .fuse_low_byte_i(fuse_lo), .fuse_high_byte_i(fuse_hi), .lock_byte_i(lock_byte),
        .load_data_o(load_data), .load_special_o(load_special), .rww_read_block_o(rww_block),
        .buf_load_o(buf_load), .buf_word_o(buf_word), .buf_data_o(buf_data), .buf_clear_o(buf_clear),
        .page_erase_o(page_erase), .page_write_o(page_write), .page_addr_o(page_addr),
        .lock_write_o(lock_write), .lock_wdata_o(lock_wdata), .spm_irq_o(spm_irq));
    fsp_cpu_model i_cpu (.clk_i(clk_i), .eeprom_write_busy_i(eeprom_busy), .reg_rdata_i(reg_rdata),
        .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
        .store_op_o(store_op), .load_op_o(load_op));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    // Returns the cycle in which the chosen pulse shows, or -1 if it does not show within n cycles.
    task automatic pulse_at(input int idx, input int n, output int at);
        at = -1;
        #1;
        for (int i = 0; i < n && at < 0; i++) begin
            if (pulses[idx] === 1'b1) begin
                at = i;
            end else begin
                @(posedge clk_i);
                #1;
            end
        end
    endtask : pulse_at
    task automatic arm(input logic [7:0] cmd, input int gap, input bit ld, input logic [15:0] ptr, input bit ee);
        @(posedge clk_i);
        addr_ptr <= ptr;
        i_cpu.wr_reg(2'h0, cmd, ee);
        i_cpu.op(gap, ld);
    endtask : arm
    task automatic t_special();
        logic [15:0] ptrs [3];
        logic [7:0] vals [3];
        logic [7:0] r;
        int p;
        ptrs = '{16'h0000, 16'h0001, 16'h0003};
        vals = '{fuse_lo, lock_byte, fuse_hi};
        for (int i = 0; i < 3; i++) begin
            arm(8'h09, 3, 1'b1, ptrs[i], 1'b1);
            pulse_at(0, 2, p);
            chk("special load", 16'h0, 16'(p));
            chk("special value", 16'(vals[i]), 16'(load_data));
        end
        i_cpu.rd_reg(2'h0, r);
        chk("control after read", 16'h0, 16'(r));
        i_cpu.op(2, 1'b1);
        pulse_at(0, 3, p);
        chk("unarmed load", 16'hffff, 16'(p));
        arm(8'h09, 4, 1'b1, 16'h0000, 1'b1);
        pulse_at(0, 3, p);
        chk("late load", 16'hffff, 16'(p));
        i_cpu.rd_reg(2'h0, r);
        chk("control after expiry", 16'h0, 16'(r));
        @(posedge clk_i);
        eeprom_busy <= 1'b1;
        arm(8'h09, 1, 1'b1, 16'h0001, 1'b0);
        pulse_at(0, 3, p);
        chk("load in eeprom write", 16'hffff, 16'(p));
        arm(8'h03, 1, 1'b0, 16'h0000, 1'b0);
        pulse_at(3, 3, p);
        chk("erase in eeprom write", 16'hffff, 16'(p));
        @(posedge clk_i);
        eeprom_busy <= 1'b0;
    endtask : t_special
    task automatic t_buffer();
        int p;
        @(posedge clk_i);
        data_high <= 8'hbe;
        data_low <= 8'hef;
        arm(8'h01, 5, 1'b0, 16'h002a, 1'b1);
        pulse_at(1, 3, p);
        chk("late store", 16'hffff, 16'(p));
        arm(8'h01, 4, 1'b0, 16'h002a, 1'b1);
        pulse_at(1, 2, p);
        chk("buffer load", 16'h0, 16'(p));
        chk("buffer word", 16'h15, 16'(buf_word));
        chk("buffer data", 16'hbeef, buf_data);
    endtask : t_buffer
    task automatic t_prog(input logic [7:0] cmd, input int idx, input bit rst);
        logic [7:0] r;
        int p, t0;
        arm(cmd, 4, 1'b0, 16'h1540, 1'b1);
        pulse_at(idx, 2, p);
        t0 = cyc;
        chk("start pulse", 16'h0, 16'(p));
        chk("page", 16'h55, 16'(page_addr));
        chk("section blocked", 16'h1, 16'(rww_block));
        if (rst) begin
            @(posedge clk_i);
            resetn_i <= 1'b0;
            repeat (2) @(posedge clk_i);
            #1;
            chk("blocked in reset", 16'h1, 16'(rww_block));
            @(posedge clk_i);
            resetn_i <= 1'b1;
        end
        i_cpu.rd_reg(2'h0, r);
        chk("status busy", 16'h41, 16'(r & 8'hc1));
        do i_cpu.rd_reg(2'h0, r); while (r[0] !== 1'b0 && cyc - t0 < 200);
        chk("run length", 16'h1, 16'(cyc - t0 >= PROG && cyc - t0 <= PROG * 45 / 37 + 6));
        chk("blocked after run", 16'h1, 16'(rww_block));
        arm(8'h11, 1, 1'b0, 16'h0000, 1'b1);
        pulse_at(2, 2, p);
        chk("buffer clear", 16'h0, 16'(p));
        pulse_at(6, 4, p);
        chk("section released", 16'h1, 16'(p >= 0));
    endtask : t_prog
    task automatic t_lock();
        logic [7:0] exp;
        logic blk;
        int n;
        arm(8'h09, 5, 1'b0, 16'h0001, 1'b1);
        pulse_at(5, PROG + 6, n);
        chk("late lock store", 16'hffff, 16'(n));
        // Bits 7, 6, 1 and 0 are cleared on purpose; the lock byte must ignore them.
        @(posedge clk_i);
        data_low <= 8'h14;
        arm(8'h09, 1, 1'b0, 16'h0001, 1'b1);
        exp = lock_byte & {2'b11, data_low[5:2], 2'b11};
        blk = 1'b0;
        n = 0;
        #1;
        while (lock_write !== 1'b1 && n < 60) begin
            blk = blk | rww_block;
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("lock time", 16'h1, 16'(n >= PROG && n <= PROG * 45 / 37 + 6));
        chk("lock data", 16'(exp), 16'(lock_wdata));
        chk("flash readable", 16'h0, 16'(blk));
    endtask : t_lock
    task automatic t_irq();
        i_cpu.wr_reg(2'h0, 8'h80, 1'b1);
        repeat (2) @(posedge clk_i);
        #1;
        chk("irq idle", 16'h1, 16'(spm_irq));
        i_cpu.wr_reg(2'h0, 8'h81, 1'b1);
        @(posedge clk_i);
        #1;
        chk("irq armed", 16'h0, 16'(spm_irq));
        repeat (6) @(posedge clk_i);
        #1;
        chk("irq after expiry", 16'h1, 16'(spm_irq));
        i_cpu.wr_reg(2'h0, 8'h00, 1'b1);
    endtask : t_irq
    task automatic print_verdict();
        $display("checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) cyc <= cyc + 1;
    initial begin
        logic [7:0] r;
        resetn_i = 1'b0;
        por_resetn_i = 1'b0;
        eeprom_busy = 1'b0;
        addr_ptr = 16'h0000;
        data_low = 8'hff;
        data_high = 8'hff;
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        por_resetn_i <= 1'b1;
        i_cpu.rd_reg(2'h1, r);
        chk("unmapped read", 16'h0, 16'(r));
        t_special();
        t_buffer();
        t_prog(8'h03, 3, 1'b0);
        t_prog(8'h05, 4, 1'b1);
        t_lock();
        t_irq();
        print_verdict();
    end
    // The whole sequence needs well under two thousand cycles.
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        print_verdict();
    end
endmodule : fsp_ctrl_bench
